/* File: verilog/motion_wake_sleep_detector.sv */
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// [RULE1] Main control 0x00 gives stand-by, low current, 2g; configure there.
// [RULE2] Main control 0x80 enters operating mode; programmed detection takes effect.
// [RULE3] Rate control 0x9E selects 50 Hz wake detection sample rate.
// [RULE4] Engine control 0x60 enables wake interrupt only, rest engine off.
// [RULE5] Engine control 0x76 sets 50 Hz rest rate, both interrupts enabled.
// [RULE6] Sleep force 0x01 puts detector to rest regardless of rest engine.
// [RULE7] Forcing sleep also clears the wake state bit.
// [RULE8] Host re-forces sleep after each wake when rest engine is off.
// [RULE9] Direction mask enables six directions separately; reset value 0x3F.
// [RULE10] Wake declared after motion persists the programmed count of wake samples.
// [RULE11] Rest declared after motion absent the programmed count of rest samples.
// [RULE12] Wake threshold is 11 bits, low byte plus high bits 10:8, reset zero.
// [RULE13] Upper high-bits field serves the rest threshold, never wake threshold.
// [RULE14] Rest threshold register sets rest level at 256 counts per g.
// [RULE15] Pin config 0x30 makes the interrupt pin active high and latched.
// [RULE16] Route map 0x02 routes the wake event to interrupt pin one.
// [RULE17] Wake event asserts latched interrupt, sets wake flag and wake state.
// [RULE18] Reading latch release drops the latched pin and clears wake flag.
// [RULE19] Event flags set on event and only a release read clears them.
// [RULE20] Wake state bit reads 1 in wake state, 0 in rest state.
// [RULE21] Rest state only reports no motion; sampling continues in run mode.
// [RULE22] Host changes detector configuration only in stand-by.
// [RULE23] Motion judged per enabled direction against threshold at each detector sample.
module motion_wake_sleep_detector #(
	parameter int unsigned P_BASE_RATE_CYC = motion_wake_pkg::BASE_RATE_CYC
) (
	input  wire logic                           i_core_clk,
	input  wire logic                           i_rst_b,
	input  wire motion_wake_pkg::reg_req_t      i_reg,
	input  wire motion_wake_pkg::accel_sample_t i_sample,
	output logic [7:0]                          o_reg_rdata,
	output logic                                o_interrupt_pin_one,
	output logic                                o_wake_state
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] rate_period(input logic [2:0] code);
		logic [2:0] sh;
		sh = motion_wake_pkg::RATE_CODE_MAX - code;
		rate_period = P_BASE_RATE_CYC[31:0] << sh;
	endfunction : rate_period

	function automatic logic exceeds(input logic signed [15:0] s, input logic [10:0] th,
	                                 input logic en_pos, input logic en_neg);
		logic signed [16:0] v;
		logic signed [16:0] t;
		v = {s[15], s};
		t = $signed({6'h00, th});
		exceeds = (en_pos && (v > t)) || (en_neg && ((-v) > t));
	endfunction : exceeds

	function automatic logic any_motion(input motion_wake_pkg::detector_state_t s,
	                                    input logic [10:0] th);
		any_motion = exceeds(s.x, th, s.motion_direction_mask[4], s.motion_direction_mask[5])
		          || exceeds(s.y, th, s.motion_direction_mask[2], s.motion_direction_mask[3])
		          || exceeds(s.z, th, s.motion_direction_mask[0], s.motion_direction_mask[1]);
	endfunction : any_motion

	function automatic logic persist_done(input logic [7:0] cnt, input logic [7:0] lim);
		persist_done = ({1'b0, cnt} + 9'h001) >= {1'b0, lim};
	endfunction : persist_done

	// ****************************************
	// State
	// ****************************************
	motion_wake_pkg::detector_state_t st_q;
	motion_wake_pkg::detector_state_t st_d;

	logic        operating;
	logic [10:0] wake_th;
	logic [10:0] rest_th;
	logic        wake_tick;
	logic        rest_tick;
	logic        wake_event;
	logic        rest_event;
	logic        force_sleep;
	logic        release_rd;
	logic        pin_level;

	// [RULE1] stand-by
	// [RULE2] operating mode
	assign operating   = st_q.main_control[motion_wake_pkg::MAIN_OPERATE_BIT];
	// [RULE12] wake threshold
	assign wake_th     = {st_q.threshold_high_bits[2:0], st_q.motion_threshold_low};
	// [RULE13] rest high bits
	// [RULE14] rest threshold
	assign rest_th     = {st_q.threshold_high_bits[6:4], st_q.rest_threshold};
	assign force_sleep = i_reg.wr && (i_reg.addr == motion_wake_pkg::ADDR_SLEEP_FORCE)
	                  && i_reg.wdata[motion_wake_pkg::SLEEP_FORCE_BIT];
	assign release_rd  = i_reg.rd && (i_reg.addr == motion_wake_pkg::ADDR_LATCH_RELEASE);

	// ****************************************
	// Detector sample ticks
	// ****************************************
	// [RULE3] wake rate
	assign wake_tick = operating
	                && (st_q.wake_div >= rate_period(st_q.rate_control[2:0]) - 32'h1);
	// [RULE5] rest rate
	assign rest_tick = operating
	                && (st_q.rest_div >= rate_period(st_q.motion_engine_control[2:0]) - 32'h1);

	// [RULE10] wake persistence
	// [RULE23] per-direction judging
	assign wake_event = wake_tick && !st_q.wake_state && !force_sleep
	                 && st_q.motion_engine_control[motion_wake_pkg::ENG_WAKE_EN_BIT]
	                 && any_motion(st_q, wake_th)
	                 && persist_done(st_q.wake_cnt, st_q.motion_persist_count);
	// [RULE11] rest persistence
	assign rest_event = rest_tick && st_q.wake_state && !force_sleep
	                 && st_q.motion_engine_control[motion_wake_pkg::ENG_REST_EN_BIT]
	                 && !any_motion(st_q, rest_th)
	                 && persist_done(st_q.rest_cnt, st_q.rest_persist_count);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic irq_en;
		logic routed;
		irq_en = st_q.motion_engine_control[motion_wake_pkg::ENG_IRQ_EN_BIT];
		routed = (wake_event && st_q.irq_route_map[motion_wake_pkg::ROUTE_WAKE_BIT])
		      || (rest_event && st_q.irq_route_map[motion_wake_pkg::ROUTE_REST_BIT]);
		st_d = st_q;

		// [RULE21] sampling continues in both states
		if (i_sample.valid) begin
			st_d.x = i_sample.x;
			st_d.y = i_sample.y;
			st_d.z = i_sample.z;
		end

		st_d.wake_div = wake_tick ? 32'h0 : (operating ? st_q.wake_div + 32'h1 : 32'h0);
		st_d.rest_div = rest_tick ? 32'h0 : (operating ? st_q.rest_div + 32'h1 : 32'h0);

		// [RULE10] count consecutive motion samples
		if (!operating || st_q.wake_state || wake_event) begin
			st_d.wake_cnt = 8'h00;
		end else if (wake_tick) begin
			st_d.wake_cnt = any_motion(st_q, wake_th) ? st_q.wake_cnt + 8'h01 : 8'h00;
		end
		// [RULE11] count consecutive quiet samples
		if (!operating || !st_q.wake_state || rest_event) begin
			st_d.rest_cnt = 8'h00;
		end else if (rest_tick) begin
			st_d.rest_cnt = any_motion(st_q, rest_th) ? 8'h00 : st_q.rest_cnt + 8'h01;
		end

		// [RULE20] wake state
		// [RULE17] wake sets state
		if (wake_event) begin
			st_d.wake_state = 1'b1;
		end else if (rest_event) begin
			st_d.wake_state = 1'b0;
		end
		// [RULE6] manual sleep
		// [RULE7] clears wake state
		if (force_sleep) begin
			st_d.wake_state = 1'b0;
			st_d.wake_cnt   = 8'h00;
			st_d.rest_cnt   = 8'h00;
		end

		// [RULE18] release clears flags and latch
		if (release_rd) begin
			st_d.motion_wake_flag    = 1'b0;
			st_d.return_to_rest_flag = 1'b0;
			st_d.irq_latch           = 1'b0;
		end
		// [RULE19] set wins over release
		// [RULE4] interrupts gated by engine control
		if (wake_event && irq_en) begin
			st_d.motion_wake_flag = 1'b1;
		end
		if (rest_event && irq_en) begin
			st_d.return_to_rest_flag = 1'b1;
		end
		// [RULE16] routing to pin one
		// [RULE17] latched interrupt
		if (routed && irq_en) begin
			st_d.irq_latch = 1'b1;
		end
		st_d.irq_pulse = routed && irq_en;

		if (i_reg.wr) begin
			case (i_reg.addr)
				motion_wake_pkg::ADDR_MAIN_CONTROL:   st_d.main_control = i_reg.wdata;
				motion_wake_pkg::ADDR_RATE_CONTROL:   st_d.rate_control = i_reg.wdata;
				motion_wake_pkg::ADDR_ENGINE_CONTROL: st_d.motion_engine_control = i_reg.wdata;
				motion_wake_pkg::ADDR_IRQ_PIN_CONFIG: st_d.irq_pin_config = i_reg.wdata;
				// [RULE9] direction mask
				motion_wake_pkg::ADDR_DIRECTION_MASK: st_d.motion_direction_mask = i_reg.wdata;
				motion_wake_pkg::ADDR_IRQ_ROUTE_MAP:  st_d.irq_route_map = i_reg.wdata;
				motion_wake_pkg::ADDR_MOTION_TH_LOW:  st_d.motion_threshold_low = i_reg.wdata;
				motion_wake_pkg::ADDR_TH_HIGH_BITS:   st_d.threshold_high_bits = i_reg.wdata;
				motion_wake_pkg::ADDR_REST_THRESHOLD: st_d.rest_threshold = i_reg.wdata;
				motion_wake_pkg::ADDR_REST_PERSIST:   st_d.rest_persist_count = i_reg.wdata;
				motion_wake_pkg::ADDR_MOTION_PERSIST: st_d.motion_persist_count = i_reg.wdata;
				default: begin
				end
			endcase
		end

		st_d.rdata = motion_wake_pkg::REG_ZERO;
		if (i_reg.rd) begin
			case (i_reg.addr)
				motion_wake_pkg::ADDR_STATE_STATUS:   st_d.rdata = {7'h00, st_q.wake_state};
				motion_wake_pkg::ADDR_EVENT_STATUS:   st_d.rdata = {6'h00,
					st_q.motion_wake_flag, st_q.return_to_rest_flag};
				motion_wake_pkg::ADDR_MAIN_CONTROL:   st_d.rdata = st_q.main_control;
				motion_wake_pkg::ADDR_RATE_CONTROL:   st_d.rdata = st_q.rate_control;
				motion_wake_pkg::ADDR_ENGINE_CONTROL: st_d.rdata = st_q.motion_engine_control;
				motion_wake_pkg::ADDR_IRQ_PIN_CONFIG: st_d.rdata = st_q.irq_pin_config;
				motion_wake_pkg::ADDR_DIRECTION_MASK: st_d.rdata = st_q.motion_direction_mask;
				motion_wake_pkg::ADDR_IRQ_ROUTE_MAP:  st_d.rdata = st_q.irq_route_map;
				motion_wake_pkg::ADDR_MOTION_TH_LOW:  st_d.rdata = st_q.motion_threshold_low;
				motion_wake_pkg::ADDR_TH_HIGH_BITS:   st_d.rdata = st_q.threshold_high_bits;
				motion_wake_pkg::ADDR_REST_THRESHOLD: st_d.rdata = st_q.rest_threshold;
				motion_wake_pkg::ADDR_REST_PERSIST:   st_d.rdata = st_q.rest_persist_count;
				motion_wake_pkg::ADDR_MOTION_PERSIST: st_d.rdata = st_q.motion_persist_count;
				default:                              st_d.rdata = motion_wake_pkg::REG_ZERO;
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			st_q                       <= '0;
			// [RULE9] all six directions after reset
			st_q.motion_direction_mask <= motion_wake_pkg::MASK_RESET;
			// Detector starts awake so a first forced sleep arms it
			st_q.wake_state            <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// [RULE15] polarity and latch mode
	assign pin_level = st_q.irq_pin_config[motion_wake_pkg::PIN_PULSE_BIT]
	                 ? st_q.irq_pulse : st_q.irq_latch;
	assign o_interrupt_pin_one = st_q.irq_pin_config[motion_wake_pkg::PIN_ENABLE_BIT]
	      && (pin_level == st_q.irq_pin_config[motion_wake_pkg::PIN_ACTIVE_HIGH_BIT]);
	assign o_reg_rdata  = st_q.rdata;
	assign o_wake_state = st_q.wake_state;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);

	sequence s_sleep_write;
		force_sleep;
	endsequence

	sequence s_rest_after;
		##1 !st_q.wake_state;
	endsequence

	sequence s_release;
		release_rd && !wake_event && !rest_event;
	endsequence

	a_force_sleep_rest: assert property (s_sleep_write |-> s_rest_after) // [RULE7]
		else $error("forced sleep did not clear wake state");
	a_release_clears_all: assert property (s_release |=> !st_q.motion_wake_flag
		&& !st_q.irq_latch && !st_q.return_to_rest_flag) // [RULE18]
		else $error("release read left flag or latch set");
	a_flag_holds_set: assert property (st_q.motion_wake_flag && !release_rd
		|=> st_q.motion_wake_flag) // [RULE19]
		else $error("wake flag cleared without release read");
	a_wake_needs_persist: assert property ($rose(st_q.motion_wake_flag)
		|-> $past(persist_done(st_q.wake_cnt, st_q.motion_persist_count))
		&& $past(operating)) // [RULE10]
		else $error("wake flag rose before persistence met");
	a_rest_needs_quiet: assert property ($rose(st_q.return_to_rest_flag)
		|-> !st_q.wake_state && $past(!any_motion(st_q, rest_th))) // [RULE11]
		else $error("rest flag rose while motion present");
	a_wake_sets_three: assert property (wake_event
		&& st_q.motion_engine_control[motion_wake_pkg::ENG_IRQ_EN_BIT]
		&& st_q.irq_route_map[motion_wake_pkg::ROUTE_WAKE_BIT]
		|=> st_q.wake_state && st_q.motion_wake_flag && st_q.irq_latch) // [RULE17]
		else $error("wake event did not set state, flag and latch");
	a_pin_latched_high: assert property (st_q.irq_pin_config == 8'h30 && st_q.irq_latch
		&& !release_rd |=> st_q.irq_latch && o_interrupt_pin_one) // [RULE15]
		else $error("latched active high pin dropped early");
	a_standby_no_count: assert property (!operating |=> st_q.wake_cnt == 8'h00
		&& st_q.rest_cnt == 8'h00) // [RULE1]
		else $error("detector counted in stand-by");
	a_high_bits_split: assert property (i_reg.wr && i_reg.addr == motion_wake_pkg::ADDR_TH_HIGH_BITS
		|=> wake_th[10:8] == $past(i_reg.wdata[2:0])
		&& rest_th[10:8] == $past(i_reg.wdata[6:4])) // [RULE13]
		else $error("threshold high bits misplaced");
	a_mask_after_reset: assert property ($rose(i_rst_b)
		|-> st_q.motion_direction_mask == motion_wake_pkg::MASK_RESET) // [RULE9]
		else $error("direction mask reset value wrong");
	a_high_bits_reset: assert property ($rose(i_rst_b)
		|-> st_q.threshold_high_bits == motion_wake_pkg::REG_ZERO) // [RULE12]
		else $error("threshold high bits not zero after reset");

	// ****************************************
	// State and event checks
	// ****************************************
	sequence s_wake_fire;
		wake_event;
	endsequence

	sequence s_wake_seen;
		##1 st_q.wake_state && o_wake_state;
	endsequence

	sequence s_rest_fire;
		rest_event;
	endsequence

	sequence s_rest_seen;
		##1 !st_q.wake_state && !o_wake_state;
	endsequence

	a_wake_enters_state: assert property (s_wake_fire |-> s_wake_seen) // [RULE20]
		else $error("wake event did not enter wake state");
	a_rest_enters_state: assert property (s_rest_fire |-> s_rest_seen) // [RULE20]
		else $error("rest event did not enter rest state");
	a_no_tick_standby: assert property (!operating |-> !wake_tick && !rest_tick) // [RULE1]
		else $error("detector ticked in stand-by");
	a_wake_needs_run: assert property ($rose(st_q.wake_state)
		|-> $past(wake_event) && $past(operating)) // [RULE2]
		else $error("wake state rose without a wake event");
	a_rest_needs_cause: assert property ($fell(st_q.wake_state)
		|-> $past(force_sleep) || $past(rest_event)) // [RULE6]
		else $error("wake state fell without force or rest event");
	a_rest_flag_holds: assert property (st_q.return_to_rest_flag && !release_rd
		|=> st_q.return_to_rest_flag) // [RULE19]
		else $error("rest flag cleared without release read");
	a_wake_flag_cause: assert property ($rose(st_q.motion_wake_flag)
		|-> $past(wake_event)) // [RULE19]
		else $error("wake flag rose without wake event");
	a_rest_flag_cause: assert property ($rose(st_q.return_to_rest_flag)
		|-> $past(rest_event)) // [RULE19]
		else $error("rest flag rose without rest event");
	a_latch_holds_set: assert property (st_q.irq_latch && !release_rd
		|=> st_q.irq_latch) // [RULE17]
		else $error("latch dropped without release read");
	a_latch_needs_route: assert property ($rose(st_q.irq_latch)
		|-> $past(wake_event && st_q.irq_route_map[motion_wake_pkg::ROUTE_WAKE_BIT])
		|| $past(rest_event && st_q.irq_route_map[motion_wake_pkg::ROUTE_REST_BIT])) // [RULE16]
		else $error("latch set by an unrouted event");
	a_pin_disabled_low: assert property
		(!st_q.irq_pin_config[motion_wake_pkg::PIN_ENABLE_BIT]
		|-> !o_interrupt_pin_one) // [RULE15]
		else $error("disabled interrupt pin asserted");
	a_sample_kept: assert property (i_sample.valid |=> st_q.x == $past(i_sample.x)
		&& st_q.y == $past(i_sample.y) && st_q.z == $past(i_sample.z)) // [RULE21]
		else $error("valid sample not stored");
	a_release_reads_zero: assert property (release_rd
		|=> o_reg_rdata == motion_wake_pkg::REG_ZERO) // [RULE18]
		else $error("release read returned nonzero data");
	a_state_readback: assert property (i_reg.rd
		&& i_reg.addr == motion_wake_pkg::ADDR_STATE_STATUS
		|=> o_reg_rdata == {7'h00, $past(st_q.wake_state)}) // [RULE20]
		else $error("state status read wrong");
	a_event_readback: assert property (i_reg.rd
		&& i_reg.addr == motion_wake_pkg::ADDR_EVENT_STATUS
		|=> o_reg_rdata == {6'h00, $past(st_q.motion_wake_flag),
		$past(st_q.return_to_rest_flag)}) // [RULE17]
		else $error("event status read wrong");
	a_wake_quiet_clear: assert property (wake_tick && !st_q.wake_state
		&& !any_motion(st_q, wake_th) |=> st_q.wake_cnt == 8'h00) // [RULE10]
		else $error("wake count kept after a quiet sample");
	a_rest_motion_clear: assert property (rest_tick && st_q.wake_state
		&& any_motion(st_q, rest_th) |=> st_q.rest_cnt == 8'h00) // [RULE11]
		else $error("rest count kept after a motion sample");

endmodule : motion_wake_sleep_detector

`default_nettype wire

/* File: verilog/motion_wake_pkg.sv */
package motion_wake_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADDR_STATE_STATUS     = 8'h17;
	localparam logic [7:0] ADDR_EVENT_STATUS     = 8'h18;
	localparam logic [7:0] ADDR_LATCH_RELEASE    = 8'h19;
	localparam logic [7:0] ADDR_MAIN_CONTROL     = 8'h1a;
	localparam logic [7:0] ADDR_RATE_CONTROL     = 8'h1c;
	localparam logic [7:0] ADDR_ENGINE_CONTROL   = 8'h1d;
	localparam logic [7:0] ADDR_SLEEP_FORCE      = 8'h1e;
	localparam logic [7:0] ADDR_IRQ_PIN_CONFIG   = 8'h20;
	localparam logic [7:0] ADDR_DIRECTION_MASK   = 8'h21;
	localparam logic [7:0] ADDR_IRQ_ROUTE_MAP    = 8'h23;
	localparam logic [7:0] ADDR_MOTION_TH_LOW    = 8'h3c;
	localparam logic [7:0] ADDR_TH_HIGH_BITS     = 8'h3d;
	localparam logic [7:0] ADDR_REST_THRESHOLD   = 8'h3e;
	localparam logic [7:0] ADDR_REST_PERSIST     = 8'h3f;
	localparam logic [7:0] ADDR_MOTION_PERSIST   = 8'h40;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int         MAIN_OPERATE_BIT      = 7;
	localparam int         ENG_IRQ_EN_BIT        = 6;
	localparam int         ENG_WAKE_EN_BIT       = 5;
	localparam int         ENG_REST_EN_BIT       = 4;
	localparam int         SLEEP_FORCE_BIT       = 0;
	localparam int         PIN_ENABLE_BIT        = 5;
	localparam int         PIN_ACTIVE_HIGH_BIT   = 4;
	localparam int         PIN_PULSE_BIT         = 3;
	localparam int         ROUTE_WAKE_BIT        = 1;
	localparam int         ROUTE_REST_BIT        = 3;
	localparam int         EVT_WAKE_BIT          = 1;
	localparam int         EVT_REST_BIT          = 0;
	localparam logic [7:0] MASK_RESET            = 8'h3f;
	localparam logic [7:0] REG_ZERO              = 8'h00;
	localparam logic [2:0] RATE_CODE_MAX         = 3'h7;

	// ****************************************
	// Timing: rate code 7 is the base rate, each lower code halves it
	// ****************************************
	localparam int         CORE_CLK_PERIOD_NS    = 10;
	localparam int         BASE_RATE_PERIOD_NS   = 10000000;
	localparam int         BASE_RATE_CYC         = BASE_RATE_PERIOD_NS / CORE_CLK_PERIOD_NS;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic               valid;
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic signed [15:0] z;
	} accel_sample_t;

	typedef struct packed {
		logic [7:0]         main_control;
		logic [7:0]         rate_control;
		logic [7:0]         motion_engine_control;
		logic [7:0]         irq_pin_config;
		logic [7:0]         motion_direction_mask;
		logic [7:0]         irq_route_map;
		logic [7:0]         motion_threshold_low;
		logic [7:0]         threshold_high_bits;
		logic [7:0]         rest_threshold;
		logic [7:0]         rest_persist_count;
		logic [7:0]         motion_persist_count;
		logic               wake_state;
		logic               motion_wake_flag;
		logic               return_to_rest_flag;
		logic               irq_latch;
		logic               irq_pulse;
		logic [7:0]         wake_cnt;
		logic [7:0]         rest_cnt;
		logic [31:0]        wake_div;
		logic [31:0]        rest_div;
		logic [7:0]         rdata;
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic signed [15:0] z;
	} detector_state_t;

endpackage : motion_wake_pkg

/* File: tb/motion_sample_source.sv */
`timescale 1ns/10ps
`default_nettype none

module motion_sample_source #(
	parameter int P_GAP = 4
) (
	input  wire logic                           i_core_clk,
	input  wire logic                           i_rst_b,
	input  wire logic signed [15:0]             i_x,
	input  wire logic signed [15:0]             i_y,
	input  wire logic signed [15:0]             i_z,
	output var  motion_wake_pkg::accel_sample_t o_sample
);
	int gap_q;

	// ****************************************
	// Sample pacing
	// ****************************************
	// continuous sampling
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b || gap_q == P_GAP - 1) begin
			gap_q <= 0;
		end else begin
			gap_q <= gap_q + 1;
		end
	end

	// Fields carry inverted data outside the strobe so stale values never look valid
	always_comb begin
		o_sample.valid = i_rst_b && (gap_q == P_GAP - 1);
		o_sample.x     = o_sample.valid ? i_x : ~i_x;
		o_sample.y     = o_sample.valid ? i_y : ~i_y;
		o_sample.z     = o_sample.valid ? i_z : ~i_z;
	end
endmodule : motion_sample_source

`default_nettype wire

/* File: tb/motion_wake_sleep_detector_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module motion_wake_sleep_detector_tb;
	logic                           i_core_clk;
	logic                           i_rst_b;
	motion_wake_pkg::reg_req_t      reg_req;
	motion_wake_pkg::accel_sample_t sample;
	logic [7:0]                     rdata;
	logic                           pin;
	logic                           wake;
	logic signed [15:0]             ax;
	logic signed [15:0]             ay;
	logic signed [15:0]             az;
	logic [7:0]                     got;
	int                             n_fail;
	int                             checks;

	motion_wake_sleep_detector #(.P_BASE_RATE_CYC(8)) i_motion_wake_sleep_detector (
		.i_core_clk         (i_core_clk),
		.i_rst_b            (i_rst_b),
		.i_reg              (reg_req),
		.i_sample           (sample),
		.o_reg_rdata        (rdata),
		.o_interrupt_pin_one(pin),
		.o_wake_state       (wake)
	);

	motion_sample_source #(.P_GAP(4)) i_motion_sample_source (
		.i_core_clk(i_core_clk),
		.i_rst_b   (i_rst_b),
		.i_x       (ax),
		.i_y       (ay),
		.i_z       (az),
		.o_sample  (sample)
	);

	always #5 i_core_clk = ~i_core_clk;

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_core_clk);
		reg_req.wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge i_core_clk);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge i_core_clk);
		reg_req.rd <= 1'b0;
		#1;
		got = rdata;
	endtask : rd

	task automatic acc(input logic signed [15:0] x, input logic signed [15:0] y,
			input logic signed [15:0] z);
		@(posedge i_core_clk);
		ax <= x;
		ay <= y;
		az <= z;
	endtask : acc

	task automatic idle(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask : idle

	task automatic wait_for(input int n, ref logic s, input logic lvl);
		for (int i = 0; i < n && s !== lvl; i++) begin
			@(posedge i_core_clk);
			#1;
		end
		check({7'h00, s}, {7'h00, lvl});
	endtask : wait_for

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize

	initial begin
		#100000;
		n_fail++;
		summarize();
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		i_core_clk = 1'b0;
		i_rst_b    = 1'b0;
		reg_req    = '0;
		ax         = '0;
		ay         = '0;
		az         = '0;
		n_fail     = 0;
		checks     = 0;
		repeat (12) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		#1;
		check({7'h00, pin}, 8'h00);
		rd(motion_wake_pkg::ADDR_DIRECTION_MASK);
		check(got, 8'h3f);
		rd(motion_wake_pkg::ADDR_TH_HIGH_BITS);
		check(got, 8'h00);
		rd(8'h50);
		check(got, 8'h00);
		acc(16'sd0, 16'sd0, -16'sd200);
		wr(motion_wake_pkg::ADDR_MAIN_CONTROL, 8'h00);
		wr(motion_wake_pkg::ADDR_RATE_CONTROL, 8'h9e);
		wr(motion_wake_pkg::ADDR_ENGINE_CONTROL, 8'h60);
		wr(motion_wake_pkg::ADDR_SLEEP_FORCE, 8'h01);
		check({7'h00, wake}, 8'h00);
		rd(motion_wake_pkg::ADDR_STATE_STATUS);
		check(got, 8'h00);
		wr(motion_wake_pkg::ADDR_DIRECTION_MASK, 8'h3f);
		wr(motion_wake_pkg::ADDR_MOTION_PERSIST, 8'h05);
		wr(motion_wake_pkg::ADDR_MOTION_TH_LOW, 8'h80);
		wr(motion_wake_pkg::ADDR_TH_HIGH_BITS, 8'h70);
		wr(motion_wake_pkg::ADDR_IRQ_PIN_CONFIG, 8'h30);
		wr(motion_wake_pkg::ADDR_IRQ_ROUTE_MAP, 8'h02);
		idle(150);
		check({7'h00, wake}, 8'h00);
		rd(motion_wake_pkg::ADDR_TH_HIGH_BITS);
		check(got, 8'h70);
		acc(16'sd128, -16'sd128, 16'sd128);
		wr(motion_wake_pkg::ADDR_MAIN_CONTROL, 8'h80);
		idle(200);
		check({7'h00, pin}, 8'h00);
		acc(16'sd0, 16'sd0, -16'sd129);
		idle(50);
		check({7'h00, pin}, 8'h00);
		wait_for(120, pin, 1'b1);
		check({7'h00, wake}, 8'h01);
		rd(motion_wake_pkg::ADDR_EVENT_STATUS);
		check(got, 8'h02);
		rd(motion_wake_pkg::ADDR_STATE_STATUS);
		check(got, 8'h01);
		idle(100);
		rd(motion_wake_pkg::ADDR_EVENT_STATUS);
		check(got, 8'h02);
		rd(motion_wake_pkg::ADDR_LATCH_RELEASE);
		check({7'h00, pin}, 8'h00);
		rd(motion_wake_pkg::ADDR_EVENT_STATUS);
		check(got, 8'h00);
		acc(16'sd0, 16'sd0, 16'sd0);
		idle(150);
		check({7'h00, wake}, 8'h01);
		wr(motion_wake_pkg::ADDR_SLEEP_FORCE, 8'h01);
		check({7'h00, wake}, 8'h00);
		acc(16'sd200, 16'sd0, 16'sd0);
		wait_for(200, pin, 1'b1);
		rd(motion_wake_pkg::ADDR_LATCH_RELEASE);
		wr(motion_wake_pkg::ADDR_MAIN_CONTROL, 8'h00);
		wr(motion_wake_pkg::ADDR_ENGINE_CONTROL, 8'h76);
		wr(motion_wake_pkg::ADDR_REST_PERSIST, 8'h05);
		wr(motion_wake_pkg::ADDR_TH_HIGH_BITS, 8'h00);
		wr(motion_wake_pkg::ADDR_REST_THRESHOLD, 8'h80);
		acc(16'sd0, 16'sd0, 16'sd0);
		wr(motion_wake_pkg::ADDR_MAIN_CONTROL, 8'h80);
		idle(50);
		check({7'h00, wake}, 8'h01);
		wait_for(150, wake, 1'b0);
		rd(motion_wake_pkg::ADDR_EVENT_STATUS);
		check(got, 8'h01);
		check({7'h00, pin}, 8'h00);
		acc(16'sd0, 16'sd300, 16'sd0);
		wait_for(150, wake, 1'b1);
		rd(motion_wake_pkg::ADDR_EVENT_STATUS);
		check(got, 8'h03);
		check({7'h00, pin}, 8'h01);
		rd(motion_wake_pkg::ADDR_LATCH_RELEASE);
		rd(motion_wake_pkg::ADDR_EVENT_STATUS);
		check(got, 8'h00);
		summarize();
	end
endmodule : motion_wake_sleep_detector_tb

`default_nettype wire
